// *** common/ofs_defs.svh ***
// constants for the output fault supervisor
`ifndef OFS_DEFS_SVH
`define OFS_DEFS_SVH
// soft-start ramp time in microseconds, typical
`define OFS_SS_TIME_US 4500
`define OFS_CLK_MHZ 100
// ramp length in clock cycles
`define OFS_SS_CYCLES (`OFS_SS_TIME_US * `OFS_CLK_MHZ)
// sense comparator filter length in cycles
`define OFS_FILT_LEN 2
`endif

// *** common/ofs_pkg.sv ***
// types for the output fault supervisor
package ofs_pkg;
   // sense comparator results, one bit each
   typedef struct packed {
      logic above_over;   // sense above over-voltage threshold
      logic below_half;   // sense below half reference
      logic below_under;  // sense below under-voltage threshold
      logic in_window;    // sense inside output-good window
   } ofs_cmp_t;
   // gate enables toward the drivers
   typedef struct packed {
      logic high_side_gate_en;
      logic low_side_gate_en;
   } ofs_gate_t;
   // supervisor phases
   typedef enum logic [1:0] {
      OFS_ST_WAIT = 2'b00,
      OFS_ST_RAMP = 2'b01,
      OFS_ST_RUN = 2'b11
   } ofs_state_t;
endpackage

// *** verilog/ofs_filter.sv ***
// two-sample agreement filter for one comparator bit
module ofs_filter (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // comparator bit in, filtered bit out
   input wire logic raw_i,
   output logic filt_o
);
   logic [1:0] hist_reg;
   // shift history; output changes only when both samples agree
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hist_reg <= 2'h0;
      end else begin
         hist_reg <= {hist_reg[0], raw_i};
      end
   end
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         filt_o <= 1'b0;
      end else if (hist_reg[1] == hist_reg[0]) begin
         filt_o <= hist_reg[0];
      end
   end
endmodule

// *** verilog/ofs_top.sv ***
// output monitoring and fault protection of a step-down controller
// What this block does
// - leaving window drops good flag, keeps regulating
// - good flag first rises at ramp end
// - under-voltage kills both gates, latched
// - over-voltage: high off, low on, latched
// - low gate released below half reference
// - latched: low gate re-on above threshold
// - open sense pulls high, seen as over-voltage
// - ramp lasts typical 4.5 ms, ends good gating
// - ramp waits for supply good, threshold setup
`include "ofs_defs.svh"
module ofs_top #(
   parameter int unsigned SS_CYCLES = `OFS_SS_CYCLES
) (
   // clock and reset (reset is the supply power-on)
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // start qualifiers
   input wire logic supply_good_i,
   input wire logic ocset_done_i,
   // sense comparators
   input wire ofs_pkg::ofs_cmp_t output_sense_input_i,
   // gate requests from the pwm loop
   input wire ofs_pkg::ofs_gate_t pwm_gate_i,
   // gate enables and status
   output ofs_pkg::ofs_gate_t gate_o,
   output logic output_good_flag_o,
   output logic under_voltage_fault_o,
   output logic over_voltage_fault_o,
   output logic soft_start_done_o
);
   // ==========================================================
   // comparator filtering
   ofs_pkg::ofs_cmp_t cmp_f;
   logic [3:0] cmp_raw;
   logic [3:0] cmp_filt;
   assign cmp_raw = output_sense_input_i;
   assign cmp_f = cmp_filt;
   // one filter per comparator bit to reject single-cycle glitches
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_filt
         ofs_filter u_filt (
            .clk_sys_i(clk_sys_i),
            .arst_n_i(arst_n_i),
            .raw_i(cmp_raw[gi]),
            .filt_o(cmp_filt[gi])
         );
      end
   endgenerate
   // ==========================================================
   // start sequencing
   ofs_pkg::ofs_state_t state_reg;
   logic [31:0] ramp_cnt_reg;
   logic monitor_on;
   assign monitor_on = (state_reg != ofs_pkg::OFS_ST_WAIT);
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= ofs_pkg::OFS_ST_WAIT;
      end else begin
         case (state_reg)
            ofs_pkg::OFS_ST_WAIT: begin
               if (supply_good_i && ocset_done_i) begin
                  state_reg <= ofs_pkg::OFS_ST_RAMP;
               end
            end
            ofs_pkg::OFS_ST_RAMP: begin
               if (ramp_cnt_reg == SS_CYCLES - 1) begin
                  state_reg <= ofs_pkg::OFS_ST_RUN;
               end
            end
            ofs_pkg::OFS_ST_RUN: state_reg <= ofs_pkg::OFS_ST_RUN;
            default: state_reg <= ofs_pkg::OFS_ST_WAIT;
         endcase
      end
   end
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ramp_cnt_reg <= 32'h0;
      end else if (state_reg == ofs_pkg::OFS_ST_RAMP) begin
         ramp_cnt_reg <= ramp_cnt_reg + 32'h1;
      end
   end
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         soft_start_done_o <= 1'b0;
      end else begin
         soft_start_done_o <= (state_reg == ofs_pkg::OFS_ST_RUN);
      end
   end
   // ==========================================================
   // fault latches; only power-on reset clears them
   logic under_trip;
   logic over_trip;
   // open sense reads high, so it lands here as over-voltage
   // open sense trips
   assign over_trip = monitor_on && cmp_f.above_over;
   // under-voltage is only meaningful once the ramp has finished
   assign under_trip = (state_reg == ofs_pkg::OFS_ST_RUN) && cmp_f.below_under;
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         under_voltage_fault_o <= 1'b0;
      end else if (under_trip) begin
         under_voltage_fault_o <= 1'b1;
      end
   end
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         over_voltage_fault_o <= 1'b0;
      end else if (over_trip) begin
         over_voltage_fault_o <= 1'b1;
      end
   end
   // ==========================================================
   // low-side crowbar during over-voltage
   logic crowbar_reg;
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         crowbar_reg <= 1'b0;
      end else if (over_trip) begin
         crowbar_reg <= 1'b1;
      end else if (cmp_f.below_half) begin
         crowbar_reg <= 1'b0;
      end
   end
   // ==========================================================
   // gate override; over-voltage outranks under-voltage so the
   // output is still pulled down after both faults have latched
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         gate_o <= '0;
      end else if (over_trip || crowbar_reg) begin
         gate_o.high_side_gate_en <= 1'b0;
         gate_o.low_side_gate_en <= 1'b1;
      end else if (over_voltage_fault_o || under_voltage_fault_o || under_trip) begin
         gate_o <= '0;
      end else if (!monitor_on) begin
         gate_o <= '0;
      end else begin
         gate_o <= pwm_gate_i;
      end
   end
   // ==========================================================
   // output-good flag
   // good after ramp
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         output_good_flag_o <= 1'b0;
      end else begin
         output_good_flag_o <= (state_reg == ofs_pkg::OFS_ST_RUN) && cmp_f.in_window
            && !under_trip && !over_trip && !under_voltage_fault_o && !over_voltage_fault_o;
      end
   end
   // ==========================================================
   // assertions
   property p_good_needs_ss;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
         output_good_flag_o |-> soft_start_done_o || $past(state_reg) == ofs_pkg::OFS_ST_RUN;
   endproperty
   a_good_needs_ss: assert property (p_good_needs_ss) else $error("good before ramp end");
   property p_window_drop;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
         !cmp_f.in_window |=> !output_good_flag_o;
   endproperty
   a_window_drop: assert property (p_window_drop) else $error("good outside window");
   property p_regulate;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
         (monitor_on && !over_trip && !crowbar_reg && !under_trip && !over_voltage_fault_o
          && !under_voltage_fault_o) |=> gate_o == $past(pwm_gate_i);
   endproperty
   a_regulate: assert property (p_regulate) else $error("pwm not passed");
   property p_under_gates_off;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
         (under_trip && !over_trip && !crowbar_reg) |=> gate_o == '0 ##1 under_voltage_fault_o;
   endproperty
   a_under_gates_off: assert property (p_under_gates_off) else $error("gates not off");
   property p_under_sticky;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
         under_voltage_fault_o |=> under_voltage_fault_o;
   endproperty
   a_under_sticky: assert property (p_under_sticky) else $error("under latch lost");
   property p_over_crowbar;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
         over_trip |=> gate_o.low_side_gate_en && !gate_o.high_side_gate_en
            && over_voltage_fault_o;
   endproperty
   a_over_crowbar: assert property (p_over_crowbar) else $error("crowbar missing");
   property p_release;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
         (crowbar_reg && cmp_f.below_half && !over_trip) |=> ##1 !gate_o.low_side_gate_en;
   endproperty
   a_release: assert property (p_release) else $error("low gate not released");
   property p_rearm;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
         (over_voltage_fault_o && !crowbar_reg && cmp_f.above_over) |=> crowbar_reg;
   endproperty
   a_rearm: assert property (p_rearm) else $error("no re-arm");
   // filter needs three edges, the latch a fourth, seen at the next sample, so no spare cycle
   property p_open_sense;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
         (monitor_on && output_sense_input_i.above_over) [*3] |=> ##1 over_voltage_fault_o;
   endproperty
   a_open_sense: assert property (p_open_sense) else $error("open sense missed");
   property p_wait_start;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
         (state_reg == ofs_pkg::OFS_ST_WAIT && !(supply_good_i && ocset_done_i))
            |=> state_reg == ofs_pkg::OFS_ST_WAIT;
   endproperty
   a_wait_start: assert property (p_wait_start) else $error("early ramp");
   property p_fault_nogood;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
         (over_voltage_fault_o || under_voltage_fault_o) |-> !output_good_flag_o;
   endproperty
   a_fault_nogood: assert property (p_fault_nogood) else $error("good with fault");
   c_good: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      $rose(output_good_flag_o));
   c_under: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      $rose(under_voltage_fault_o));
   c_over: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      $rose(over_voltage_fault_o));
   c_release: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      $fell(crowbar_reg));
endmodule

// *** testbench/ofs_sense_model.sv ***
// sense divider and comparator model at the far side of the supervisor
module ofs_sense_model #(
   parameter int unsigned UNDER_MV = 250,
   parameter int unsigned WIN_LO_MV = 720,
   parameter int unsigned WIN_HI_MV = 880
) (
   // output voltage in millivolts, open sense pin
   input wire logic [11:0] vout_mv_i,
   input wire logic sense_open_i,
   // comparator levels toward the block
   output ofs_pkg::ofs_cmp_t cmp_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] sense_mv;
   // ==========================================
   // sense node and comparators
   // bias pull-up
   // an open pin floats to the top, far above every threshold
   assign sense_mv = sense_open_i ? 12'hfff : vout_mv_i;
   assign cmp_o.above_over = sense_mv > 12'h3e8;
   assign cmp_o.below_half = sense_mv < 12'h190;
   assign cmp_o.below_under = sense_mv < UNDER_MV;
   assign cmp_o.in_window = (sense_mv >= WIN_LO_MV) && (sense_mv <= WIN_HI_MV);
endmodule

// *** testbench/ofs_top_tb_top.sv ***
// self-checking bench for the output fault supervisor
module ofs_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned SS = 20;
   logic clk_sys_i, arst_n_i, supply_good_i, ocset_done_i, sense_open;
   logic [11:0] vout_mv;
   ofs_pkg::ofs_cmp_t cmp;
   ofs_pkg::ofs_gate_t pwm, gate;
   logic good, under_f, over_f, done;
   int bad_count, tests_run;
   // ==========================================
   // design, far side and clock
   ofs_top #(.SS_CYCLES(SS)) i_dut (
      .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .supply_good_i(supply_good_i),
      .ocset_done_i(ocset_done_i), .output_sense_input_i(cmp), .pwm_gate_i(pwm),
      .gate_o(gate), .output_good_flag_o(good), .under_voltage_fault_o(under_f),
      .over_voltage_fault_o(over_f), .soft_start_done_o(done));
   ofs_sense_model i_sense (.vout_mv_i(vout_mv), .sense_open_i(sense_open), .cmp_o(cmp));
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // ==========================================
   // shared tasks
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   // compares {gate, good, under_f, over_f, done}
   task automatic chk(input string what, input logic [5:0] exp);
      logic [5:0] got;
      got = {gate, good, under_f, over_f, done};
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic do_reset();
      @(negedge clk_sys_i);
      arst_n_i = 1'b0;
      {supply_good_i, ocset_done_i, sense_open} = 3'h0;
      vout_mv = 12'h320;
      pwm = 2'h2;
      wait_n(16);
      arst_n_i = 1'b1;
   endtask
   // filter plus register settle well inside six cycles
   task automatic set_v(input logic [11:0] mv);
      vout_mv = mv;
      wait_n(6);
   endtask
   task automatic power_up();
      {supply_good_i, ocset_done_i} = 2'h3;
      wait_n(SS + 10);
   endtask
   // ==========================================
   // scenarios
   task automatic t_start();
      do_reset();
      wait_n(5);
      chk("idle", 6'h00);
      supply_good_i = 1'b1;
      wait_n(10);
      chk("no_ocset", 6'h00);
      ocset_done_i = 1'b1;
      wait_n(10);
      chk("ramp", 6'h20);
      // ramp spans SS cycles: done and good one edge later, not before
      wait_n(SS - 9);
      chk("ramp_end", 6'h20);
      wait_n(1);
      chk("run", 6'h29);
   endtask
   task automatic t_window();
      set_v(12'h384);
      chk("above_win", 6'h21);
      pwm = 2'h1;
      wait_n(4);
      chk("follow", 6'h11);
      // single-cycle spike above the trip level must be ignored
      vout_mv = 12'h44c;
      wait_n(1);
      vout_mv = 12'h384;
      wait_n(5);
      chk("glitch", 6'h11);
      set_v(12'h320);
      chk("back_in", 6'h19);
   endtask
   task automatic t_ov();
      set_v(12'h44c);
      chk("ov_trip", 6'h13);
      set_v(12'h320);
      chk("ov_hold", 6'h13);
      set_v(12'h15e);
      chk("ov_release", 6'h03);
      set_v(12'h44c);
      chk("ov_retrip", 6'h13);
   endtask
   task automatic t_uv();
      do_reset();
      power_up();
      set_v(12'h0c8);
      chk("uv_trip", 6'h05);
      set_v(12'h320);
      chk("uv_latched", 6'h05);
   endtask
   task automatic t_open();
      do_reset();
      pwm = 2'h2;
      power_up();
      sense_open = 1'b1;
      wait_n(6);
      chk("open_sense", 6'h13);
   endtask
   // ==========================================
   // verdict, main sequence and watchdog
   task automatic finish_test();
      if (bad_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      arst_n_i = 1'b0;
      {supply_good_i, ocset_done_i, sense_open} = 3'h0;
      vout_mv = 12'h320;
      pwm = 2'h2;
      bad_count = 0;
      tests_run = 0;
      t_start();
      t_window();
      t_ov();
      t_uv();
      t_open();
      finish_test();
   end
   // whole run needs a few microseconds; this cuts a hang
   initial begin
      #200000;
      bad_count++;
      finish_test();
   end
endmodule
